/* File: common/dir_ctrl_pkg.sv */
package dir_ctrl_pkg;
    // register map
    localparam logic [7:0] PWR_RST_OFS = 8'h00;
    localparam int SOFT_RST_POS = 0;
    localparam int RECOV_PWR_POS = 1;
    localparam logic [7:0] PWR_RST_RESET = 8'h03;
    // reference crystal select codes
    localparam logic [1:0] XSEL_11M2896 = 2'h0;
    localparam logic [1:0] XSEL_12M288 = 2'h1;
    localparam logic [1:0] XSEL_24M576 = 2'h2;
    localparam logic [1:0] XSEL_CHSTAT = 2'h3;
    // rate codes
    localparam logic [3:0] FS_44K1 = 4'h0;
    localparam logic [3:0] FS_NONE = 4'h1;
    localparam logic [3:0] FS_48K = 4'h2;
    localparam logic [3:0] FS_32K = 4'h3;
    localparam logic [3:0] FS_22K05 = 4'h4;
    localparam logic [3:0] FS_11K025 = 4'h5;
    localparam logic [3:0] FS_24K = 4'h6;
    localparam logic [3:0] FS_16K = 4'h7;
    localparam logic [3:0] FS_88K2 = 4'h8;
    localparam logic [3:0] FS_8K = 4'h9;
    localparam logic [3:0] FS_96K = 4'ha;
    localparam logic [3:0] FS_64K = 4'hb;
    localparam logic [3:0] FS_176K4 = 4'hc;
    localparam logic [3:0] FS_OOR = 4'hd;
    localparam logic [3:0] FS_192K = 4'he;
    // frame count of one status block, block start stays high frames 0..39
    localparam int BLOCK_FRAMES = 192;
    localparam logic [7:0] BLOCK_HIGH_LAST = 8'h27;
    // de-emphasis filter modes
    typedef enum logic [1:0] {
        DEEMPH_44K1 = 2'h0,
        DEEMPH_OFF = 2'h1,
        DEEMPH_48K = 2'h2,
        DEEMPH_32K = 2'h3
    } deemph_mode_t;
    // channel status fields used by the block
    typedef struct packed {
        logic [7:0] byte0;
        logic [7:0] byte3;
        logic [7:0] byte4;
    } chstat_t;
    // serial control fields
    typedef struct packed {
        logic [1:0] ref_crystal_sel;
        logic preemph_channel_sel;
        logic deemph_auto_sel;
        logic [1:0] deemph_manual_field;
        logic [2:0] input_select_field;
        logic block_output_enable;
        logic user_or_channel_select;
    } ctrl_t;
endpackage : dir_ctrl_pkg

/* File: verilog/dir_rate_deemph_input_ctrl.sv */
// Summary of operation
// - crystal select 00/01/10 picks clock comparison reference, 00 default
// - crystal select 11 takes rate code from channel status
// - parallel mode forces crystal select to 10
// - clock comparison reports rate code within three percent of nominal
// - rate between nominals gives no valid code; far outside gives 0001 or 1101
// - consumer status copies byte 3 bits 3..0 to rate code
// - professional status maps byte0[7:6], byte4[6:3]; unlisted gives 0001
// - pre-emphasis read from channel 1, channel 2 when channel select set
// - flag set when byte 0 bits 1-5 match 0X100
// - alternate table: flag set when byte 0 bits 2-4 equal 110
// - auto mode picks 44.1k/48k/32k by rate code, else filter off
// - manual field chooses filter when auto deselected in serial mode
// - parallel mode always uses auto de-emphasis from channel 1
// - data bypasses filter when mode off or flag zero
// - power-down pin low resets everything and blocks register access
// - soft reset bit zero resets registers; only bits 1..0 writable, no reads
// - recovery power bit zero resets recovery, registers stay accessible
// - parallel mode honours only the power-down pin
// - serial input select 000..101 routes inputs 1..6; 110, 111 unused
// - parallel mode: input select pin low picks input 1, high input 5
// - block enable switches mux pins between clock/irq and block/U/C
// - block start high from frame 0 through end of frame 39
`timescale 1ns/1ps
module dir_rate_deemph_input_ctrl #(
    parameter int PERIOD_W = 16,
    parameter logic [PERIOD_W-1:0] TOL_PCT = 16'h0003
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_power_down_pin_n,
    input wire logic i_parallel_mode,
    input wire logic i_input_select_pin,
    // register port, one access per strobe
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // serial control fields held elsewhere in the register file
    input wire dir_ctrl_pkg::ctrl_t i_ctrl,
    // received stream side
    input wire logic [5:0] i_receiver_inputs,
    input wire logic i_frame_start,
    input wire logic i_status_valid,
    input wire logic i_status_professional,
    input wire dir_ctrl_pkg::chstat_t i_chstat_ch1,
    input wire dir_ctrl_pkg::chstat_t i_chstat_ch2,
    // measured frame period in reference clock ticks, one-cycle valid
    input wire logic i_period_valid,
    input wire logic [PERIOD_W-1:0] i_period,
    input wire logic i_preemph_alt_table,
    input wire logic [23:0] i_audio,
    input wire logic [23:0] i_audio_filtered,
    input wire logic i_second_master_clock,
    input wire logic i_second_irq,
    input wire logic i_user_bit,
    input wire logic i_chan_bit,
    output logic o_selected_input,
    output logic o_recovery_reset,
    output logic o_core_reset,
    output logic [3:0] o_rate_code,
    output logic o_preemph_flag,
    output dir_ctrl_pkg::deemph_mode_t o_deemph_mode,
    output logic [23:0] o_audio,
    output logic o_second_master_clock_pin,
    output logic o_second_irq_pin,
    output logic o_block_start
);

    // ==========================================================
    // functions
    // ==========================================================
    // nominal period table: frame period in ticks of a 24.576MHz reference
    function automatic logic [PERIOD_W-1:0] nominal(input logic [3:0] code);
        case (code)
            4'h0: nominal = 16'd557;
            4'h2: nominal = 16'd512;
            4'h3: nominal = 16'd768;
            4'h4: nominal = 16'd1115;
            4'h5: nominal = 16'd2229;
            4'h6: nominal = 16'd1024;
            4'h7: nominal = 16'd1536;
            4'h8: nominal = 16'd279;
            4'h9: nominal = 16'd3072;
            4'ha: nominal = 16'd256;
            4'hb: nominal = 16'd384;
            4'hc: nominal = 16'd139;
            4'he: nominal = 16'd128;
            default: nominal = 16'd0;
        endcase
    endfunction : nominal

    // true when the period lies within tolerance of a nominal value
    function automatic logic near(input logic [PERIOD_W-1:0] p, input logic [PERIOD_W-1:0] n);
        logic [PERIOD_W+7:0] d;
        logic [PERIOD_W+7:0] lim;
        d = (p > n) ? {8'h00, p - n} : {8'h00, n - p};
        lim = {8'h00, n} * {8'h00, TOL_PCT};
        near = (n != '0) && ((d * 100) <= lim);
    endfunction : near

    // ==========================================================
    // reset and register access
    // ==========================================================
    logic [7:0] pwr_reg;
    logic [7:0] pwr_next;
    logic hard_rst;
    logic soft_rst_bit;
    logic recov_pwr_bit;
    logic core_rst;
    logic reg_hit;

    // power-down pin acts like a reset; parallel mode ignores the bits
    assign hard_rst = i_rst | ~i_power_down_pin_n;
    assign soft_rst_bit = i_parallel_mode | pwr_reg[dir_ctrl_pkg::SOFT_RST_POS];
    assign recov_pwr_bit = i_parallel_mode | pwr_reg[dir_ctrl_pkg::RECOV_PWR_POS];
    assign core_rst = hard_rst | ~soft_rst_bit;
    assign reg_hit = (i_reg_addr == dir_ctrl_pkg::PWR_RST_OFS);
    // only the two low bits exist; writes stay legal during soft reset
    assign pwr_next = (i_reg_wr && reg_hit) ? {6'h00, i_reg_wdata[1:0]} : pwr_reg;

    // control register, lost only on pin or system reset
    always_ff @(posedge i_clk) begin
        if (hard_rst) begin
            pwr_reg <= dir_ctrl_pkg::PWR_RST_RESET;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // reads are blocked while held in soft reset or power-down
    always_ff @(posedge i_clk) begin
        if (core_rst) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            o_reg_rdata <= (i_reg_rd && reg_hit) ? pwr_reg : 8'h00;
        end
    end

    // recovery reset keeps registers but stops clock recovery
    always_ff @(posedge i_clk) begin
        if (hard_rst) begin
            o_recovery_reset <= 1'b1;
            o_core_reset <= 1'b1;
        end else begin
            o_recovery_reset <= ~soft_rst_bit | ~recov_pwr_bit;
            o_core_reset <= ~soft_rst_bit;
        end
    end

    // ==========================================================
    // rate detection
    // ==========================================================
    logic [1:0] xsel;
    logic [3:0] cmp_code;
    logic [3:0] cs_code;
    logic [3:0] rate_next;
    logic [PERIOD_W-1:0] scaled;
    dir_ctrl_pkg::chstat_t cs_pre;

    assign xsel = i_parallel_mode ? dir_ctrl_pkg::XSEL_24M576 : i_ctrl.ref_crystal_sel;

    // periods from slower references scale up to the 24.576MHz table
    assign scaled = (xsel == dir_ctrl_pkg::XSEL_24M576) ? i_period :
                    (xsel == dir_ctrl_pkg::XSEL_12M288) ? PERIOD_W'(i_period << 1) :
                    PERIOD_W'((i_period * 24576) / 11290);

    // scan the nominal table; the gap between nominals gives no code
    always_comb begin
        cmp_code = dir_ctrl_pkg::FS_NONE;
        for (int k = 0; k < 16; k++) begin
            if (near(scaled, nominal(4'(k)))) begin
                cmp_code = 4'(k);
            end
        end
        if (scaled < 16'd100) begin
            cmp_code = dir_ctrl_pkg::FS_OOR;
        end
    end

    // channel status decoding, consumer copies, professional maps
    always_comb begin
        cs_code = dir_ctrl_pkg::FS_NONE;
        if (!i_status_professional) begin
            cs_code = i_chstat_ch1.byte3[3:0];
        end else begin
            case ({i_chstat_ch1.byte0[7:6], i_chstat_ch1.byte4[6:3]})
                6'h10: cs_code = dir_ctrl_pkg::FS_44K1;
                6'h20: cs_code = dir_ctrl_pkg::FS_48K;
                6'h30: cs_code = dir_ctrl_pkg::FS_32K;
                6'h09: cs_code = dir_ctrl_pkg::FS_22K05;
                6'h01: cs_code = dir_ctrl_pkg::FS_24K;
                6'h0a: cs_code = dir_ctrl_pkg::FS_88K2;
                6'h02: cs_code = dir_ctrl_pkg::FS_96K;
                6'h0b: cs_code = dir_ctrl_pkg::FS_176K4;
                6'h03: cs_code = dir_ctrl_pkg::FS_192K;
                default: cs_code = dir_ctrl_pkg::FS_NONE;
            endcase
        end
    end

    assign rate_next = (xsel == dir_ctrl_pkg::XSEL_CHSTAT) ?
                       (i_status_valid ? cs_code : o_rate_code) :
                       (i_period_valid ? cmp_code : o_rate_code);

    // rate code register
    always_ff @(posedge i_clk) begin
        if (core_rst) begin
            o_rate_code <= dir_ctrl_pkg::FS_NONE;
        end else begin
            o_rate_code <= rate_next;
        end
    end

    // ==========================================================
    // pre-emphasis and de-emphasis
    // ==========================================================
    logic pem_next;
    logic pem_a;
    logic pem_b;
    dir_ctrl_pkg::deemph_mode_t auto_mode;
    dir_ctrl_pkg::deemph_mode_t mode_next;
    logic use_auto;

    // parallel mode always reads channel 1
    assign cs_pre = (i_ctrl.preemph_channel_sel && !i_parallel_mode) ?
                    i_chstat_ch2 : i_chstat_ch1;
    // bits 1..5 read 0,x,1,0,0 in rising bit order, as the second table reads bits 2..4;
    // bit 1 low keeps non-audio streams from raising the flag with the first table; the second table ignores bit 1
    assign pem_a = (cs_pre.byte0[1] == 1'b0) && (cs_pre.byte0[5:3] == 3'b001);
    assign pem_b = (cs_pre.byte0[4:2] == 3'b011);
    assign pem_next = i_preemph_alt_table ? pem_b : pem_a;

    assign use_auto = i_parallel_mode | i_ctrl.deemph_auto_sel;
    assign auto_mode = (o_rate_code == dir_ctrl_pkg::FS_44K1) ? dir_ctrl_pkg::DEEMPH_44K1 :
                       (o_rate_code == dir_ctrl_pkg::FS_48K) ? dir_ctrl_pkg::DEEMPH_48K :
                       (o_rate_code == dir_ctrl_pkg::FS_32K) ? dir_ctrl_pkg::DEEMPH_32K :
                       dir_ctrl_pkg::DEEMPH_OFF;
    assign mode_next = !o_preemph_flag ? dir_ctrl_pkg::DEEMPH_OFF :
                       use_auto ? auto_mode :
                       dir_ctrl_pkg::deemph_mode_t'(i_ctrl.deemph_manual_field);

    // flag and filter mode registers
    always_ff @(posedge i_clk) begin
        if (core_rst) begin
            o_preemph_flag <= 1'b0;
            o_deemph_mode <= dir_ctrl_pkg::DEEMPH_OFF;
        end else begin
            if (i_status_valid) begin
                o_preemph_flag <= pem_next;
            end
            o_deemph_mode <= mode_next;
        end
    end

    // filter bypass follows the registered mode, one cycle behind
    always_ff @(posedge i_clk) begin
        if (core_rst) begin
            o_audio <= 24'h00_0000;
        end else begin
            o_audio <= (o_deemph_mode == dir_ctrl_pkg::DEEMPH_OFF) ? i_audio
                       : i_audio_filtered;
        end
    end

    // ==========================================================
    // input select and multiplexed pins
    // ==========================================================
    logic [2:0] in_idx;
    logic in_bit;
    logic [7:0] frame_cnt_reg;
    logic [7:0] frame_cnt_next;

    assign in_idx = i_parallel_mode ? (i_input_select_pin ? 3'h4 : 3'h0)
                    : i_ctrl.input_select_field;
    // unused codes leave the recovery path quiet
    assign in_bit = (in_idx <= 3'h5) ? i_receiver_inputs[in_idx] : 1'b0;

    // frame counter restarts on each block start marker
    assign frame_cnt_next = i_status_valid ? 8'h00 :
                            (i_frame_start && frame_cnt_reg != 8'hff) ? frame_cnt_reg + 8'h01
                            : frame_cnt_reg;

    always_ff @(posedge i_clk) begin
        if (core_rst) begin
            o_selected_input <= 1'b0;
            frame_cnt_reg <= 8'hff;
            o_second_master_clock_pin <= 1'b0;
            o_second_irq_pin <= 1'b0;
            o_block_start <= 1'b0;
        end else begin
            o_selected_input <= in_bit;
            frame_cnt_reg <= frame_cnt_next;
            o_block_start <= (frame_cnt_next <= dir_ctrl_pkg::BLOCK_HIGH_LAST);
            o_second_master_clock_pin <= i_ctrl.block_output_enable
                ? (frame_cnt_next <= dir_ctrl_pkg::BLOCK_HIGH_LAST)
                : i_second_master_clock;
            o_second_irq_pin <= !i_ctrl.block_output_enable ? i_second_irq
                : (i_ctrl.user_or_channel_select ? i_chan_bit : i_user_bit);
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    a_read_blocked: assert property (@(posedge i_clk) disable iff (i_rst)
        core_rst |=> !o_reg_rvalid)
        else $error("read answered during soft reset");
    a_pdn_reg_init: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_power_down_pin_n |=> pwr_reg == dir_ctrl_pkg::PWR_RST_RESET)
        else $error("register not initialised by power-down");
    a_deemph_bypass: assert property (@(posedge i_clk) disable iff (core_rst)
        o_deemph_mode == dir_ctrl_pkg::DEEMPH_OFF |=> o_audio == $past(i_audio))
        else $error("audio not bypassed");
    a_pem_off_mode: assert property (@(posedge i_clk) disable iff (core_rst)
        !o_preemph_flag |=> o_deemph_mode == dir_ctrl_pkg::DEEMPH_OFF)
        else $error("filter on without pre-emphasis");
    a_cons_copy: assert property (@(posedge i_clk) disable iff (core_rst)
        (xsel == dir_ctrl_pkg::XSEL_CHSTAT && i_status_valid && !i_status_professional)
        |=> o_rate_code == $past(i_chstat_ch1.byte3[3:0]))
        else $error("consumer rate code not copied");
    a_par_input: assert property (@(posedge i_clk) disable iff (core_rst)
        (i_parallel_mode && !i_input_select_pin) |=> o_selected_input == $past(i_receiver_inputs[0]))
        else $error("parallel input 1 not routed");
    a_block_mux: assert property (@(posedge i_clk) disable iff (core_rst)
        !i_ctrl.block_output_enable |=> o_second_irq_pin == $past(i_second_irq))
        else $error("interrupt not passed to pin");
    a_block_high: assert property (@(posedge i_clk) disable iff (core_rst)
        i_status_valid |=> o_block_start)
        else $error("block start not high at frame 0");
    a_manual_mode: assert property (@(posedge i_clk) disable iff (core_rst)
        (o_preemph_flag && !i_parallel_mode && !i_ctrl.deemph_auto_sel)
        |=> o_deemph_mode == $past(i_ctrl.deemph_manual_field))
        else $error("manual de-emphasis field not applied");
    c_chstat_rate: cover property (@(posedge i_clk) xsel == dir_ctrl_pkg::XSEL_CHSTAT && i_status_valid);
    c_deemph_on: cover property (@(posedge i_clk) o_deemph_mode == dir_ctrl_pkg::DEEMPH_48K);
    c_soft_reset: cover property (@(posedge i_clk) !i_rst && o_core_reset);
    c_manual_deemph: cover property (@(posedge i_clk) o_preemph_flag && !i_ctrl.deemph_auto_sel);
endmodule : dir_rate_deemph_input_ctrl

/* File: verif/biphase_src_model.sv */
`timescale 1ns/1ps
// ====
// frame timing of the received stream
module biphase_src_model #(
    parameter int FRAME_CYC = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    output logic o_frame_start,
    output logic o_status_valid
);
    int cyc_cnt;
    int frm_cnt;
    // short frames keep a 192-frame status block quick to simulate
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cyc_cnt <= 0;
            frm_cnt <= 0;
        end else begin
            cyc_cnt <= (cyc_cnt == FRAME_CYC - 1) ? 0 : cyc_cnt + 1;
            if (cyc_cnt == FRAME_CYC - 1) begin
                frm_cnt <= (frm_cnt == dir_ctrl_pkg::BLOCK_FRAMES - 1) ? 0 : frm_cnt + 1;
            end
        end
    end
    // new status block marked on frame 0 only
    assign o_frame_start = (cyc_cnt == 0) && !i_rst;
    assign o_status_valid = o_frame_start && (frm_cnt == 0);
endmodule : biphase_src_model

/* File: verif/dir_rate_deemph_input_ctrl_tb_top.sv */
`timescale 1ns/1ps
module dir_rate_deemph_input_ctrl_tb_top;
    localparam int FRM = 4;
    logic i_clk = 0, i_rst = 1, pdn_n = 1, par = 0, ips_pin = 0;
    logic wr = 0, rd = 0, pv = 0, prof = 0, fs, sv;
    logic [7:0] addr = 0, wdata = 0, rdata;
    logic rvalid, sel_in, rec_rst, core_rst, preemph_flag, mck_pin, irq_pin, blk;
    logic [5:0] rx = 0;
    logic [15:0] period = 0;
    logic [23:0] aud = 0, aud_f = 0, aud_o;
    logic mck = 0, irq = 0, ubit = 0, cbit = 0;
    logic alt_tab = 0;
    logic [1:0] mf = 0;
    logic [3:0] rate;
    dir_ctrl_pkg::deemph_mode_t dmode;
    dir_ctrl_pkg::ctrl_t ctrl = '0;
    dir_ctrl_pkg::chstat_t cs1 = '0, cs2 = '0;
    typedef struct {string what; logic [23:0] exp;} note_t;
    note_t rd_q[$], smp_q[$];
    int failures = 0, n_compared = 0, cycles = 0;
    event look;
    logic [9:0] prof_tab [10] = '{10'h100, 10'h202, 10'h303, 10'h094, 10'h016,
                                  10'h0a8, 10'h02a, 10'h0bc, 10'h03e, 10'h0f1};
    logic [15:0] per_tab [5] = '{16'd512, 16'd768, 16'd557, 16'd1024, 16'd50};
    logic [3:0] fs_tab [5] = '{dir_ctrl_pkg::FS_48K, dir_ctrl_pkg::FS_32K,
        dir_ctrl_pkg::FS_44K1, dir_ctrl_pkg::FS_24K, dir_ctrl_pkg::FS_OOR};

    always #2.5 i_clk = ~i_clk;

    dir_rate_deemph_input_ctrl dut_u (.i_clk(i_clk), .i_rst(i_rst),
        .i_power_down_pin_n(pdn_n), .i_parallel_mode(par), .i_input_select_pin(ips_pin),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_ctrl(ctrl), .i_receiver_inputs(rx),
        .i_frame_start(fs), .i_status_valid(sv), .i_status_professional(prof),
        .i_chstat_ch1(cs1), .i_chstat_ch2(cs2), .i_period_valid(pv), .i_period(period),
        .i_preemph_alt_table(alt_tab), .i_audio(aud), .i_audio_filtered(aud_f),
        .i_second_master_clock(mck), .i_second_irq(irq), .i_user_bit(ubit),
        .i_chan_bit(cbit), .o_selected_input(sel_in), .o_recovery_reset(rec_rst),
        .o_core_reset(core_rst), .o_rate_code(rate), .o_preemph_flag(preemph_flag),
        .o_deemph_mode(dmode), .o_audio(aud_o), .o_second_master_clock_pin(mck_pin),
        .o_second_irq_pin(irq_pin), .o_block_start(blk));
    biphase_src_model #(.FRAME_CYC(FRM)) src_u (.i_clk(i_clk), .i_rst(i_rst),
        .o_frame_start(fs), .o_status_valid(sv));

    // ====
    // helpers
    function automatic logic [23:0] seen(string what);
        case (what)
            "rate": seen = 24'(rate);
            "pem": seen = 24'(preemph_flag);
            "mode": seen = 24'(dmode);
            "audio": seen = aud_o;
            "sel": seen = 24'(sel_in);
            "irq_pin": seen = 24'(irq_pin);
            "mck_pin": seen = 24'(mck_pin);
            "blk": seen = 24'(blk);
            "core_rst": seen = 24'(core_rst);
            default: seen = 24'(rec_rst);
        endcase
    endfunction : seen
    task automatic compare(input string what, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : compare
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc
    // zero-time note; the watcher looks 1 ns later, once the edge has settled,
    // so a run of notes never slides the caller across a clock edge
    task automatic expect_out(input string what, input logic [23:0] e);
        smp_q.push_back('{what, e});
        -> look;
    endtask : expect_out
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge i_clk);
        wr <= 0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input bit answered);
        @(posedge i_clk);
        if (answered) rd_q.push_back('{"rdata", 24'(e)});
        rd <= 1;
        addr <= a;
        @(posedge i_clk);
        rd <= 0;
        cyc(2);
    endtask : reg_rd
    task automatic period_in(input logic [15:0] p, input logic [3:0] e);
        @(posedge i_clk);
        pv <= 1;
        period <= p;
        @(posedge i_clk);
        pv <= 0;
        cyc(2);
        expect_out("rate", 24'(e));
    endtask : period_in
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // ====
    // watchers: sampled notes, and read data at mid-cycle while rvalid stands
    always @(look) begin : smp_watch
        note_t n;
        #1;
        while (smp_q.size() > 0) begin
            n = smp_q.pop_front();
            compare(n.what, n.exp, seen(n.what));
        end
    end
    always @(negedge i_clk) begin : rd_watch
        note_t n;
        if (rvalid === 1'b1) begin
            if (rd_q.size() == 0) begin
                compare("unasked rvalid", 24'h0, 24'h1);
            end else begin
                n = rd_q.pop_front();
                compare(n.what, n.exp, 24'(rdata));
            end
        end
    end
    // a hang ends the run as a failure
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            close_out();
        end
    end

    // ====
    // main sequence
    initial begin
        void'($urandom(45754));
        ctrl.deemph_auto_sel = 1;
        cyc(4);
        i_rst <= 0;
        pdn_n <= 0;
        cyc(1);
        pdn_n <= 1;
        cs2 <= dir_ctrl_pkg::chstat_t'({8'h00, 16'($urandom)});
        reg_rd(8'h00, 8'h03, 1);
        reg_rd(8'h10, 8'h00, 1);
        reg_wr(8'h00, 8'hfd);
        reg_rd(8'h00, 8'h01, 1);
        expect_out("rec_rst", 24'h1);
        reg_wr(8'h00, 8'h02);
        cyc(2);
        expect_out("core_rst", 24'h1);
        reg_rd(8'h00, 8'h00, 0);
        reg_wr(8'h00, 8'h03);
        cyc(2);
        expect_out("core_rst", 24'h0);
        expect_out("rec_rst", 24'h0);
        reg_wr(8'h00, 8'h01);
        pdn_n <= 0;
        cyc(2);
        pdn_n <= 1;
        reg_rd(8'h00, 8'h03, 1);
        for (int s = 0; s < 6; s++) begin
            rx <= 6'($urandom);
            ctrl.input_select_field <= 3'(s);
            cyc(3);
            expect_out("sel", 24'(rx[s]));
        end
        for (int m = 0; m < 3; m++) begin
            {mck, irq, ubit, cbit} <= 4'($urandom);
            ctrl.block_output_enable <= (m > 0);
            ctrl.user_or_channel_select <= (m == 2);
            cyc(3);
            expect_out("irq_pin", 24'(m == 0 ? irq : (m == 1 ? ubit : cbit)));
            if (m == 0) expect_out("mck_pin", 24'(mck));
        end
        ctrl.ref_crystal_sel <= dir_ctrl_pkg::XSEL_24M576;
        for (int i = 0; i < 5; i++) period_in(per_tab[i], fs_tab[i]);
        period_in(16'd540, dir_ctrl_pkg::FS_NONE);
        // slower references: 256 ticks is 48k at 12.288MHz and 44.1k at 11.2896MHz
        ctrl.ref_crystal_sel <= dir_ctrl_pkg::XSEL_12M288;
        period_in(16'd256, dir_ctrl_pkg::FS_48K);
        ctrl.ref_crystal_sel <= dir_ctrl_pkg::XSEL_11M2896;
        period_in(16'd256, dir_ctrl_pkg::FS_44K1);
        // parallel strapping overrides the serial fields
        par <= 1;
        ctrl.ref_crystal_sel <= dir_ctrl_pkg::XSEL_CHSTAT;
        period_in(16'd768, dir_ctrl_pkg::FS_32K);
        for (int p = 0; p < 2; p++) begin
            rx <= 6'($urandom);
            ips_pin <= p[0];
            cyc(3);
            expect_out("sel", 24'(p ? rx[4] : rx[0]));
        end
        reg_wr(8'h00, 8'h00);
        cyc(2);
        expect_out("core_rst", 24'h0);
        par <= 0;
        reg_wr(8'h00, 8'h03);
        aud <= 24'($urandom);
        aud_f <= 24'($urandom);
        for (int i = 0; i < 13; i++) begin
            prof <= (i > 2);
            if (i < 3) cs1.byte3 <= 8'($urandom);
            else cs1.byte0[7:6] <= prof_tab[i-3][9:8];
            if (i > 2) cs1.byte4[6:3] <= prof_tab[i-3][7:4];
            @(posedge sv);
            cyc(3);
            if (i < 3) expect_out("rate", 24'(cs1.byte3[3:0]));
            else expect_out("rate", 24'(prof_tab[i-3][3:0]));
            expect_out("pem", 24'h0);
            expect_out("mode", 24'(dir_ctrl_pkg::DEEMPH_OFF));
            expect_out("audio", aud);
            if (i == 0) begin
                expect_out("blk", 24'h1);
                cyc(30 * FRM);
                expect_out("blk", 24'h1);
                cyc(20 * FRM);
                expect_out("blk", 24'h0);
            end
        end
        // pre-emphasis from channel 2 only: auto filter at 48k, then the manual field
        prof <= 0;
        cs1.byte3 <= {4'h0, dir_ctrl_pkg::FS_48K};
        ctrl.preemph_channel_sel <= 1;
        for (int k = 0; k < 2; k++) begin
            mf = 2'($urandom);
            alt_tab <= k[0];
            ctrl.deemph_auto_sel <= !k[0];
            ctrl.deemph_manual_field <= mf;
            // 08 passes only the first table, 2c only the second
            cs2.byte0 <= k ? 8'h2c : 8'h08;
            @(posedge sv);
            cyc(3);
            expect_out("pem", 24'h1);
            expect_out("mode", 24'(k ? mf : 2'(dir_ctrl_pkg::DEEMPH_48K)));
            expect_out("audio", (k && mf == 2'h1) ? aud : aud_f);
        end
        // let the watcher take the last notes before the verdict
        cyc(1);
        close_out();
    end
endmodule : dir_rate_deemph_input_ctrl_tb_top
